// *** hdl/irq_defines.svh ***
`ifndef IRQ_DEFINES_SVH
`define IRQ_DEFINES_SVH

// Byte offsets on the register bus
`define OFS_CPU_STATUS   5'h00
`define OFS_CORE_CONTROL 5'h04
`define OFS_INTCON_ONE   5'h08
`define OFS_INTCON_TWO   5'h0c
`define OFS_IFLAGS_FIRST 5'h10
`define OFS_EVT_STATUS   5'h14
`define OFS_EVT_MASK     5'h18

// Field positions
`define PRI_HI    7
`define PRI_LO    5
`define MSB_BIT   3
`define NEST_BIT  15
`define DIV0_BIT  6
`define MATH_BIT  4
`define ADDR_BIT  3
`define STACK_BIT 2
`define OSC_BIT   1
`define ALT_BIT   15
`define TDIS_BIT  14
`define EP_HI     2
`define EP_LO     0
`define EVT_REQ_BIT  0
`define EVT_TRAP_BIT 1

// Implemented bit masks
`define ICON1_MASK 16'h805e
`define ICON2_MASK 16'h8007
`define INTERRUPT_FLAGS_FIRST_MASK  16'h3fef
`define EVT_MASK   2'h3

// Reset values and constants
`define RST16     16'h0000
`define RST_PRI   3'h0
`define RST_EVT   2'h0
`define PRI_TOP   3'h7
`define ZERO_PAD  16'h0000

`endif

// *** hdl/irq_pkg.sv ***
package irq_pkg;

    typedef struct packed {
        logic div0;
        logic math;
        logic addr;
        logic stack;
        logic osc;
    } trap_events_s;

    typedef struct packed {
        logic       load;
        logic [3:0] level;
    } core_priority_s;

endpackage

// *** hdl/ext_edge_detect.sv ***
`timescale 1ns/10ps
`include "irq_defines.svh"

module ext_edge_detect (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic [2:0] pin,
    input  wire logic [2:0] polarity,
    output logic      [2:0] edge_pulse_r
);
    logic [2:0] s1_r;
    logic [2:0] s2_r;
    logic [2:0] s3_r;
    logic [2:0] lvl_r;
    wire  [2:0] lvl_nxt;
    wire  [2:0] rise;
    wire  [2:0] fall;

    // Level changes only once the two later stages agree
    assign lvl_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & lvl_r);
    assign rise    = lvl_nxt & ~lvl_r;
    assign fall    = ~lvl_nxt & lvl_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            s1_r         <= 3'h0;
            s2_r         <= 3'h0;
            s3_r         <= 3'h0;
            lvl_r        <= 3'h0;
            edge_pulse_r <= 3'h0;
        end else begin
            s1_r         <= pin;
            s2_r         <= s1_r;
            s3_r         <= s2_r;
            lvl_r        <= lvl_nxt;
            edge_pulse_r <= (polarity & fall) | (~polarity & rise);
        end
    end
endmodule

// *** hdl/cpu_priority_and_trap_status.sv ***
// How it works
// - Current CPU priority lives in cpu_status bits 7:5, reset to zero.
// - Software writes the priority field while nesting is allowed.
// - Codes 0 to 7 mean levels 0 to 7; level 7 blocks user sources.
// - Priority MSB joins the field into a 4-bit level; set blocks users.
// - Priority MSB at core_control bit 3 reads 1 when level exceeds 7.
// - Software can only clear the priority MSB; it resets to zero.
// - Nesting disable at control one bit 15 makes priority field read-only.
// - Math trap flag at bit 4 of control one sets on a math trap.
// - Stack trap flag at bit 2 sets on stack error trap.
// - Oscillator fail flag at bit 1 sets on oscillator failure trap.
// - Control two bit 15 picks the alternate vector table when 1.
// - Each first-flag bit except 4, 14 and 15 reads 1 once its source requested; reset zero.
// - Flags are set by sources and stay set until software clears them.
// - Flag bits follow natural vector order, external request 0 at bit 0.
`timescale 1ns/10ps
`include "irq_defines.svh"

module cpu_priority_and_trap_status (
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire logic [4:0]              address,
    input  wire logic                    read,
    input  wire logic                    write,
    input  wire logic [31:0]             writedata,
    input  wire logic [3:0]              byteenable,
    output logic      [31:0]             readdata,
    output logic                         waitrequest,
    input  wire irq_pkg::trap_events_s   trap_event,
    input  wire irq_pkg::core_priority_s core_priority,
    input  wire logic                    timed_disable_in,
    input  wire logic [15:1]             source_req,
    input  wire logic [2:0]              ext_irq_pin,
    output logic [3:0]                   cpu_priority_level,
    output logic                         user_irq_blocked,
    output logic                         nesting_disable,
    output logic                         alt_table_select,
    output logic [15:0]                  interrupt_flags_first,
    output logic [2:1]                   ext_irq_event,
    output logic                         irq
);
    import irq_pkg::*;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] wdat,
                                            input logic [1:0]  be);
        merge16 = {be[1] ? wdat[15:8] : old[15:8], be[0] ? wdat[7:0] : old[7:0]};
    endfunction

    logic [2:0]  pri_r;
    logic        msb_r;
    logic [15:0] icon1_r;
    logic [15:0] icon2_r;
    logic        tdis_r;
    logic [15:0] interrupt_flags_first_r;
    logic [1:0]  evt_status_r;
    logic [1:0]  evt_mask_r;
    logic [31:0] readdata_r;
    logic        waitrequest_r;
    logic        blocked_r;
    logic        irq_r;
    logic [2:1]  ext_evt_r;
    logic [2:0]  ext_edge;

    ext_edge_detect u_edge (
        .clk          (clk),
        .srst         (srst),
        .pin          (ext_irq_pin),
        .polarity     (icon2_r[`EP_HI:`EP_LO]),
        .edge_pulse_r (ext_edge)
    );

    // Bus decode
    wire        wr_go     = write && !waitrequest_r;
    wire        hit_sr    = address == `OFS_CPU_STATUS;
    wire        hit_core  = address == `OFS_CORE_CONTROL;
    wire        hit_icon1 = address == `OFS_INTCON_ONE;
    wire        hit_icon2 = address == `OFS_INTCON_TWO;
    wire        hit_interrupt_flags_first  = address == `OFS_IFLAGS_FIRST;
    wire        hit_evt   = address == `OFS_EVT_STATUS;
    wire        hit_msk   = address == `OFS_EVT_MASK;
    wire [1:0]  be16      = byteenable[1:0];
    wire [15:0] wd16      = writedata[15:0];

    // Register images
    wire [15:0] sr_img    = {8'h00, pri_r, 5'h00};
    wire [15:0] core_img  = {12'h000, msb_r, 3'h0};
    wire [15:0] icon2_img = (icon2_r & `ICON2_MASK) | ({15'h0000, tdis_r} << `TDIS_BIT);

    wire [15:0] sr_wr     = merge16(sr_img, wd16, be16);
    wire [15:0] core_wr   = merge16(core_img, wd16, be16);
    wire [15:0] icon1_wr  = merge16(icon1_r, wd16, be16);
    wire [15:0] icon2_wr  = merge16(icon2_r, wd16, be16);
    wire [15:0] interrupt_flags_first_wr   = merge16(interrupt_flags_first_r, wd16, be16);
    wire [15:0] evt_wr    = merge16({14'h0000, evt_status_r}, wd16, be16);
    wire [15:0] msk_wr    = merge16({14'h0000, evt_mask_r}, wd16, be16);

    // Priority field and MSB
    wire        sw_pri_ok = wr_go && hit_sr && !icon1_r[`NEST_BIT];
    wire [2:0]  pri_nxt   = core_priority.load ? core_priority.level[2:0] :
                            sw_pri_ok ? sr_wr[`PRI_HI:`PRI_LO] : pri_r;
    wire        msb_clr   = wr_go && hit_core && !core_wr[`MSB_BIT];
    wire        msb_nxt   = core_priority.load ? core_priority.level[3] :
                            msb_clr ? 1'b0 : msb_r;
    wire        blk_nxt   = msb_nxt || (pri_nxt == `PRI_TOP);

    // Trap flags: hardware set wins over software write
    wire [15:0] trap_set  = ({15'h0000, trap_event.div0}  << `DIV0_BIT)  |
                            ({15'h0000, trap_event.math}  << `MATH_BIT)  |
                            ({15'h0000, trap_event.addr}  << `ADDR_BIT)  |
                            ({15'h0000, trap_event.stack} << `STACK_BIT) |
                            ({15'h0000, trap_event.osc}   << `OSC_BIT);
    wire [15:0] icon1_base = (wr_go && hit_icon1) ? icon1_wr : icon1_r;
    wire [15:0] icon1_nxt = (icon1_base | trap_set) & `ICON1_MASK;

    wire [15:0] icon2_nxt = ((wr_go && hit_icon2) ? icon2_wr : icon2_r) & `ICON2_MASK;

    // First flag register, natural order with external request 0 at bit 0
    wire [15:0] src_set   = {source_req, ext_edge[0]} & `INTERRUPT_FLAGS_FIRST_MASK;
    wire [15:0] interrupt_flags_first_base = (wr_go && hit_interrupt_flags_first) ? interrupt_flags_first_wr : interrupt_flags_first_r;
    wire [15:0] interrupt_flags_first_nxt  = (interrupt_flags_first_base | src_set) & `INTERRUPT_FLAGS_FIRST_MASK;

    // Event status, write one to clear, set wins
    wire [1:0]  evt_set   = {|trap_set, |src_set};
    wire [1:0]  evt_clr   = (wr_go && hit_evt) ? evt_wr[1:0] : 2'h0;
    wire [1:0]  evt_nxt   = ((evt_status_r & ~evt_clr) | evt_set) & `EVT_MASK;
    wire [1:0]  msk_nxt   = (wr_go && hit_msk) ? (msk_wr[1:0] & `EVT_MASK) : evt_mask_r;

    // Read selection, unmapped reads zero
    wire [15:0] rd_val    = hit_sr    ? sr_img :
                            hit_core  ? core_img :
                            hit_icon1 ? (icon1_r & `ICON1_MASK) :
                            hit_icon2 ? icon2_img :
                            hit_interrupt_flags_first  ? interrupt_flags_first_r :
                            hit_evt   ? {14'h0000, evt_status_r} :
                            hit_msk   ? {14'h0000, evt_mask_r} :
                            `ZERO_PAD;

    always_ff @(posedge clk) begin
        if (srst) begin
            pri_r <= `RST_PRI;
            msb_r <= 1'b0;
        end else begin
            pri_r <= pri_nxt;
            msb_r <= msb_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            icon1_r <= `RST16;
            icon2_r <= `RST16;
            tdis_r  <= 1'b0;
            interrupt_flags_first_r  <= `RST16;
        end else begin
            icon1_r <= icon1_nxt;
            icon2_r <= icon2_nxt;
            tdis_r  <= timed_disable_in;
            interrupt_flags_first_r  <= interrupt_flags_first_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            evt_status_r <= `RST_EVT;
            evt_mask_r   <= `RST_EVT;
            irq_r        <= 1'b0;
        end else begin
            evt_status_r <= evt_nxt;
            evt_mask_r   <= msk_nxt;
            irq_r        <= |(evt_nxt & msk_nxt);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            blocked_r <= 1'b1;
            ext_evt_r <= 2'h0;
        end else begin
            blocked_r <= blk_nxt;
            ext_evt_r <= ext_edge[2:1];
        end
    end

    // Bus handshake: one wait cycle, answer on the second edge
    always_ff @(posedge clk) begin
        if (srst) begin
            waitrequest_r <= 1'b1;
            readdata_r    <= 32'h0000_0000;
        end else if (waitrequest_r && (read || write)) begin
            waitrequest_r <= 1'b0;
            readdata_r    <= {`ZERO_PAD, rd_val};
        end else begin
            waitrequest_r <= 1'b1;
        end
    end

    assign readdata              = readdata_r;
    assign waitrequest           = waitrequest_r;
    assign cpu_priority_level    = {msb_r, pri_r};
    assign user_irq_blocked      = blocked_r;
    assign nesting_disable       = icon1_r[`NEST_BIT];
    assign alt_table_select      = icon2_r[`ALT_BIT];
    assign interrupt_flags_first = interrupt_flags_first_r;
    assign ext_irq_event         = ext_evt_r;
    assign irq                   = irq_r;
endmodule

// *** testbench/irq_props.sv ***
`timescale 1ns/10ps
module irq_props (
    input wire logic                    clk,
    input wire logic                    srst,
    input wire logic                    read,
    input wire logic                    write,
    input wire logic                    waitrequest,
    input wire irq_pkg::core_priority_s core_priority,
    input wire logic [15:1]             source_req,
    input wire logic [3:0]              cpu_priority_level,
    input wire logic                    user_irq_blocked,
    input wire logic [15:0]             interrupt_flags_first
);
    import irq_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_wait_one_cycle: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("no answer after one wait cycle");
    a_wait_back_high: assert property (!waitrequest |=> waitrequest)
        else $error("answer held too long");
    a_block_level: assert property (!$past(srst) |-> user_irq_blocked ==
        (cpu_priority_level[3] || cpu_priority_level[2:0] == 3'h7)) else $error("blocked wrong");
    a_core_load_wins: assert property (core_priority.load |=>
        cpu_priority_level == $past(core_priority.level)) else $error("core level not loaded");
    a_msb_no_set: assert property ($rose(cpu_priority_level[3]) |->
        $past(core_priority.load)) else $error("msb set by software");
    a_flag_sets: assert property (source_req[13:1] != 0 |=>
        (interrupt_flags_first[13:1] & $past(source_req[13:1]) & 13'h1ff7)
        == ($past(source_req[13:1]) & 13'h1ff7)) else $error("flag not set");
    a_flag_sticky: assert property (!$past(srst) &&
        (~interrupt_flags_first & $past(interrupt_flags_first)) != 0
        |-> $past(write && !waitrequest)) else $error("flag dropped alone");
    a_unimpl_zero: assert property ({interrupt_flags_first[15:14],
        interrupt_flags_first[4]} == 3'h0) else $error("unimplemented flag set");
endmodule
bind cpu_priority_and_trap_status irq_props props_i (.clk(clk), .srst(srst), .read(read),
    .write(write), .waitrequest(waitrequest), .core_priority(core_priority),
    .source_req(source_req), .cpu_priority_level(cpu_priority_level),
    .user_irq_blocked(user_irq_blocked), .interrupt_flags_first(interrupt_flags_first));

// *** testbench/irq_src_model.sv ***
`timescale 1ns/10ps
module irq_src_model (
    input wire logic                clk,
    input wire logic                fire,
    input wire logic [24:0]         pick,
    output irq_pkg::trap_events_s   trap_event,
    output irq_pkg::core_priority_s core_priority,
    output logic [15:1]             source_req
);
    import irq_pkg::*;
    initial {trap_event, core_priority, source_req} = '0;
    // One-cycle requests, low between them
    always @(posedge clk) begin
        trap_event    <= fire ? trap_events_s'(pick[4:0]) : '0;
        source_req    <= fire ? pick[19:5] : 15'h0;
        core_priority <= fire ? core_priority_s'(pick[24:20]) : '0;
    end
endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/10ps
`include "irq_defines.svh"
module testbench;
    import irq_pkg::*;
    logic           clk, srst, read, write, fire, tdis, waitrequest, blocked, irq, nest, alt;
    logic [4:0]     address;
    logic [31:0]    writedata, readdata, r;
    logic [24:0]    pick;
    logic [2:0]     pins;
    logic [15:0]    rd, exp, d, flags;
    logic [3:0]     level, be;
    logic [2:1]     ev, seen;
    trap_events_s   trap_event;
    core_priority_s core_priority;
    logic [15:1]    source_req;
    logic [4:0]     tv [5] = '{5'h18, 5'h08, 5'h04, 5'h02, 5'h01};
    int             num_errors, checked;
    irq_src_model src (.clk(clk), .fire(fire), .pick(pick), .trap_event(trap_event),
        .core_priority(core_priority), .source_req(source_req));
    cpu_priority_and_trap_status uut (.clk(clk), .srst(srst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(be), .readdata(readdata),
        .waitrequest(waitrequest), .trap_event(trap_event), .core_priority(core_priority),
        .timed_disable_in(tdis), .source_req(source_req), .ext_irq_pin(pins),
        .cpu_priority_level(level), .user_irq_blocked(blocked), .nesting_disable(nest),
        .alt_table_select(alt), .interrupt_flags_first(flags), .ext_irq_event(ev), .irq(irq));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input string s, input logic [15:0] got, input logic [15:0] want);
        checked++;
        if (got !== want) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", s, want, got);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] v);
        int n;
        n = 0;
        address <= a;
        writedata <= {16'h0, v};
        write <= w;
        read <= !w;
        @(posedge clk);
        while (waitrequest !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        rd = readdata[15:0];
        if (n == 20) num_errors++;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rchk(input string s, input logic [4:0] a, input logic [15:0] want);
        bus(1'b0, a, 16'h0);
        chk(s, rd, want);
    endtask
    task automatic pulse(input logic [24:0] v);
        fire <= 1'b1;
        pick <= v;
        @(posedge clk);
        fire <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic pin_step(input logic [2:0] v, input logic [2:1] want);
        seen = 2'b00;
        pins <= v;
        repeat (10) begin
            @(posedge clk);
            seen = seen | ev;
        end
        chk("ext_event", {14'h0, seen}, {14'h0, want});
    endtask
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        tally_and_finish;
    end
    initial begin
        {read, write, address, writedata, fire, pick, tdis, pins} = '0;
        srst = 1'b1;
        be = 4'h3;
        r = 32'h706c;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 8; a++) rchk("reset", 5'(a * 4), 16'h0);
        for (int i = 0; i < 7; i++) begin
            r = lfsr(r);
            d = (i == 6) ? 16'hffff : r[15:0];
            bus(1'b1, `OFS_CPU_STATUS, d);
            rchk("status", `OFS_CPU_STATUS, d & 16'h00e0);
            chk("level", {12'h0, level}, {13'h0, d[7:5]});
            chk("blocked", {15'h0, blocked}, {15'h0, d[7:5] == 3'h7});
        end
        pulse({1'b1, 4'hc, 20'h0});
        chk("level", {12'h0, level}, 16'h000c);
        chk("blocked", {15'h0, blocked}, 16'h0001);
        bus(1'b1, `OFS_CORE_CONTROL, 16'hffff);
        rchk("core", `OFS_CORE_CONTROL, 16'h0008);
        bus(1'b1, `OFS_CORE_CONTROL, 16'h0);
        rchk("core", `OFS_CORE_CONTROL, 16'h0);
        bus(1'b1, `OFS_CORE_CONTROL, 16'hffff);
        rchk("core", `OFS_CORE_CONTROL, 16'h0);
        chk("level", {12'h0, level}, 16'h0004);
        chk("blocked", {15'h0, blocked}, 16'h0);
        bus(1'b1, `OFS_CPU_STATUS, 16'h0040);
        bus(1'b1, `OFS_INTCON_ONE, 16'hffff);
        chk("nest", {15'h0, nest}, 16'h0001);
        bus(1'b1, `OFS_CPU_STATUS, 16'h00e0);
        rchk("status", `OFS_CPU_STATUS, 16'h0040);
        rchk("con1", `OFS_INTCON_ONE, 16'h805e);
        bus(1'b1, `OFS_INTCON_ONE, 16'h0);
        chk("nest", {15'h0, nest}, 16'h0);
        foreach (tv[i]) begin
            pulse({20'h0, tv[i]});
            exp = {9'h0, tv[i][4], 1'b0, tv[i][3:0], 1'b0};
            rchk("con1", `OFS_INTCON_ONE, exp);
            bus(1'b1, `OFS_INTCON_ONE, 16'h0);
        end
        exp = 16'h0;
        repeat (3) begin
            r = lfsr(r);
            pulse({5'h0, r[14:0], 5'h0});
            exp = (exp | {r[14:0], 1'b0}) & 16'h3fef;
            rchk("flags", `OFS_IFLAGS_FIRST, exp);
        end
        chk("flags", flags, exp);
        bus(1'b1, `OFS_IFLAGS_FIRST, 16'h0);
        rchk("flags", `OFS_IFLAGS_FIRST, 16'h0);
        tdis <= 1'b1;
        bus(1'b1, `OFS_INTCON_TWO, 16'hfffa);
        rchk("con2", `OFS_INTCON_TWO, 16'hc002);
        chk("alt", {15'h0, alt}, 16'h0001);
        tdis <= 1'b0;
        pin_step(3'b111, 2'b10);
        pin_step(3'b000, 2'b01);
        rchk("flags", `OFS_IFLAGS_FIRST, 16'h0001);
        be <= 4'h2;
        bus(1'b1, `OFS_INTCON_TWO, 16'h0);
        be <= 4'h3;
        rchk("con2", `OFS_INTCON_TWO, 16'h0002);
        chk("alt", {15'h0, alt}, 16'h0);
        bus(1'b1, `OFS_EVT_MASK, 16'h0001);
        @(posedge clk);
        chk("irq", {15'h0, irq}, 16'h1);
        bus(1'b1, `OFS_EVT_MASK, 16'h0);
        @(posedge clk);
        chk("irq", {15'h0, irq}, 16'h0);
        rchk("evt", `OFS_EVT_STATUS, 16'h0003);
        bus(1'b1, `OFS_EVT_STATUS, 16'h0003);
        rchk("evt", `OFS_EVT_STATUS, 16'h0);
        tally_and_finish;
    end
endmodule
